// ==== dcc_params.svh ====
// Purpose: constants of the dual capture/compare array
// Assumes: 40 MHz mclk, 8-bit register address, 16-bit data
// Notes:   offsets are byte-free register indices
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
`define DCC_CLK_NS  25
`define DCC_RES_NS  200
`define DCC_TMAX    16'hffff
`define DCC_CTL_W   5
`define DCC_CTL_TSEL 4
`define DCC_TC_W    6
`define DCC_TC_RUN  0
`define DCC_TC_SRC  1
`define DCC_TC_PSC  3
`define DCC_N_CH    32
`define DCC_N_TMR   4
`define DCC_N_SRC   36
`define DCC_A_VAL   8'h00
`define DCC_A_CTL   8'h20
`define DCC_A_TCNT  8'h40
`define DCC_A_TRLD  8'h44
`define DCC_A_TCTL  8'h48
`define DCC_A_STLO  8'h4c
`define DCC_A_STHI  8'h4d
`define DCC_A_STT   8'h4e
`define DCC_A_MKLO  8'h50
`define DCC_A_MKHI  8'h51
`define DCC_A_MKT   8'h52
`define DCC_A_PRI   8'h60
`endif

// ==== dcc_pkg.sv ====
// Purpose: types of the dual capture/compare array
// Assumes: nothing
// Notes:   mode codes 9..15 are illegal and act as off
`default_nettype none
package dcc_pkg;
    typedef enum logic [3:0] {
        dcc_off, cap_rise, cap_fall, cap_both,
        cmp0, cmp1, cmp2, cmp3, cmp_dbl
    } dcc_mode_t;
    typedef enum logic [1:0] {src_psc, src_gm2, src_ext} dcc_src_t;
endpackage
`default_nettype wire

// ==== dcc_cell.sv ====
// Purpose: one capture/compare channel
// Assumes: pin_s already synchronised, tval/upd/ovf from its timer
// Notes:   capture beats a software write in the same cycle
`timescale 1ns/10ps
`default_nettype none
module dcc_cell (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  mode,
    input  wire logic [15:0] tval,
    input  wire logic        upd,
    input  wire logic        ovf,
    input  wire logic        pin_s,
    input  wire logic        pair_tgl,
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] val_q,
    output logic             ev_q,
    output logic             tgl,
    output logic             pin_q
);
    dcc_pkg::dcc_mode_t m;
    logic pin_p_q;
    logic done_q;
    logic rise;
    logic fall;
    logic cap;
    logic cmp;
    logic once;
    logic hit;
    logic first;

    assign m    = dcc_pkg::dcc_mode_t'(mode);
    assign rise = pin_s & ~pin_p_q;
    assign fall = ~pin_s & pin_p_q;

    always_comb begin
        cap  = 1'b0;
        cmp  = 1'b0;
        once = 1'b0;
        unique case (m)
            dcc_pkg::cap_rise: cap = rise;
            dcc_pkg::cap_fall: cap = fall;
            dcc_pkg::cap_both: cap = rise | fall;
            dcc_pkg::cmp0, dcc_pkg::cmp1, dcc_pkg::cmp_dbl: cmp = 1'b1;
            dcc_pkg::cmp2, dcc_pkg::cmp3: begin
                cmp  = 1'b1;
                once = 1'b1;
            end
            default: cmp = 1'b0;
        endcase
    end

    // compared only when the timer has just counted
    assign hit   = cmp & upd & (tval == val_q);
    // an overflow in the same cycle opens the new period first
    assign first = hit & ~(once & done_q & ~ovf);
    assign tgl   = hit & (m == dcc_pkg::cmp_dbl);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_p_q <= 1'b0;
        end else begin
            pin_p_q <= pin_s;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            val_q <= 16'h0000;
        end else if (cap) begin
            val_q <= tval;
        end else if (wr) begin
            val_q <= wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ev_q   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            ev_q   <= cap | first;
            done_q <= once & (first | (done_q & ~ovf));
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else if ((m == dcc_pkg::cmp1 && hit) ||
                     (m == dcc_pkg::cmp_dbl && (hit || pair_tgl))) begin
            pin_q <= ~pin_q;
        end else if (m == dcc_pkg::cmp3 && first) begin
            pin_q <= 1'b1;
        end else if (m == dcc_pkg::cmp3 && ovf) begin
            pin_q <= 1'b0;
        end
    end

    cap_latch_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        cap |=> (ev_q && val_q == $past(tval)))
        else $error("capture did not latch timer");
    edge_sel_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (m == dcc_pkg::cap_rise && fall) |=> !ev_q)
        else $error("falling edge captured in rising mode");
    cmp_irq_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (m == dcc_pkg::cmp0 && upd && tval == val_q) |=> (ev_q && $stable(pin_q)))
        else $error("mode 0 match wrong");
    mode2_once_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (m == dcc_pkg::cmp2 && done_q && !ovf) |=> !ev_q)
        else $error("second mode 2 event in period");
    mode3_pin_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (m == dcc_pkg::cmp3 && ovf && !first) |=> !pin_q)
        else $error("mode 3 pin not cleared on overflow");
    mode1_tgl_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (m == dcc_pkg::cmp1 && hit) |=> (pin_q != $past(pin_q)))
        else $error("mode 1 pin did not toggle");
    dbl_pin_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (m == dcc_pkg::cmp_dbl && pair_tgl && !hit) |=> (pin_q != $past(pin_q)))
        else $error("double mode pin did not toggle");
endmodule
`default_nettype wire

// ==== dcc_top.sv ====
// Purpose: two capture/compare arrays of 16 channels, four timers
// Assumes: pins and external count inputs are asynchronous
// Notes:   register bus is a plain strobe port, read data next cycle
//
// Overview of operation
// - 32 channels, finest timer step 16 half-clocks
// - four reloadable 16-bit timers in two pairs
// - timer clock from prescaler or module-two overflow
// - first timer of each pair counts external edges
// - 16 channels per array, timer and function selectable
// - each channel owns one pin, in or out
// - capture latches timer and raises interrupt
// - capture edge rising, falling or both
// - compare against assigned timer on every count
// - mode 0: interrupt per match, no pin
// - mode 1: pin toggles on each match
// - mode 2: one interrupt per timer period
// - mode 3: pin high on match, low on overflow
// - double mode: two channels toggle one pin
// - every source has request, enable and priority
`timescale 1ns/10ps
`default_nettype none
`include "dcc_params.svh"
module dcc_top (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata_q,
    input  wire logic [31:0] cc_pin_i,
    output logic      [31:0] cc_pin_o,
    output logic      [31:0] cc_pin_oe,
    input  wire logic        ext_cnt_a,
    input  wire logic        ext_cnt_b,
    input  wire logic        gm2_t6_ovf,
    output logic             irq,
    output logic      [3:0]  irq_prio_q
);
    localparam int RES_CYC = (`DCC_RES_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS;
    localparam int NCH     = `DCC_N_CH;
    localparam int NT      = `DCC_N_TMR;
    localparam int NSRC    = `DCC_N_SRC;

    logic [15:0]          psc_q;
    logic [15:0]          tcnt_q [NT];
    logic [15:0]          trld_q [NT];
    logic [`DCC_TC_W-1:0] tctl_q [NT];
    logic [`DCC_CTL_W-1:0] cctl_q [NCH];
    logic [3:0]           prio_q [NSRC];
    logic [NT-1:0]        cnt_en;
    logic [NT-1:0]        twr;
    logic [NT-1:0]        upd_q;
    logic [NT-1:0]        tovf_q;
    logic [31:0]          pin_s1_q;
    logic [31:0]          pin_s2_q;
    logic [1:0]           ext_s1_q;
    logic [1:0]           ext_s2_q;
    logic [1:0]           ext_p_q;
    logic [1:0]           ext_edge;
    logic [15:0]          ccv [NCH];
    logic [NCH-1:0]       ccev;
    logic [NCH-1:0]       tgl;
    logic [NCH-1:0]       st_ch_q;
    logic [NCH-1:0]       mk_ch_q;
    logic [NCH-1:0]       clr_ch;
    logic [NT-1:0]        st_t_q;
    logic [NT-1:0]        mk_t_q;
    logic [NT-1:0]        clr_t;
    logic [NSRC-1:0]      pend;
    logic [3:0]           best;
    logic [15:0]          rdata_d;
    logic [7:0]           pri_off;

    function automatic logic in_rng(input logic [7:0] a,
                                    input logic [7:0] b,
                                    input int         n);
        return (a >= b) && ({1'b0, a} < ({1'b0, b} + 9'(n)));
    endfunction

    // prescaled tick: the finest choice is one step per RES_CYC clocks
    function automatic logic psc_tick(input logic [15:0] p,
                                      input logic [2:0]  s);
        logic [15:0] msk;
        msk = 16'((RES_CYC << s) - 1);
        return &(p | ~msk);
    endfunction

    // two-flop synchronisers; edge detect reads only the second stage
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 32'h0000_0000;
            pin_s2_q <= 32'h0000_0000;
            ext_s1_q <= 2'h0;
            ext_s2_q <= 2'h0;
            ext_p_q  <= 2'h0;
        end else begin
            pin_s1_q <= cc_pin_i;
            pin_s2_q <= pin_s1_q;
            ext_s1_q <= {ext_cnt_b, ext_cnt_a};
            ext_s2_q <= ext_s1_q;
            ext_p_q  <= ext_s2_q;
        end
    end

    assign ext_edge = ext_s2_q & ~ext_p_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            psc_q <= 16'h0000;
        end else begin
            psc_q <= psc_q + 16'h0001;
        end
    end

    always_comb begin
        for (int t = 0; t < NT; t++) begin
            twr[t]    = wr && (addr == `DCC_A_TCNT + 8'(t));
            cnt_en[t] = 1'b0;
            unique case (dcc_pkg::dcc_src_t'(tctl_q[t][`DCC_TC_SRC +: 2]))
                dcc_pkg::src_psc:
                    cnt_en[t] = psc_tick(psc_q,
                                         tctl_q[t][`DCC_TC_PSC +: 3]);
                dcc_pkg::src_gm2: cnt_en[t] = gm2_t6_ovf;
                dcc_pkg::src_ext:
                    cnt_en[t] = (t % 2 == 0) && ext_edge[t / 2];
                default: cnt_en[t] = 1'b0;
            endcase
            cnt_en[t] = cnt_en[t] & tctl_q[t][`DCC_TC_RUN];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < NT; t++) begin
                tcnt_q[t] <= 16'h0000;
            end
            upd_q  <= '0;
            tovf_q <= '0;
        end else begin
            for (int t = 0; t < NT; t++) begin
                if (twr[t]) begin
                    tcnt_q[t] <= wdata;
                end else if (cnt_en[t]) begin
                    tcnt_q[t] <= (tcnt_q[t] == `DCC_TMAX) ?
                                 trld_q[t] : tcnt_q[t] + 16'h0001;
                end
            end
            upd_q  <= cnt_en & ~twr;
            for (int t = 0; t < NT; t++) begin
                tovf_q[t] <= cnt_en[t] && !twr[t] &&
                             (tcnt_q[t] == `DCC_TMAX);
            end
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam int P = i ^ 8;
        logic [1:0] ti;
        dcc_pkg::dcc_mode_t cm;
        // array picks the pair, the channel picks a timer within it
        assign ti = {1'(i / 16), cctl_q[i][`DCC_CTL_TSEL]};
        assign cm = dcc_pkg::dcc_mode_t'(cctl_q[i][3:0]);
        // upper channel of a double pair never drives its own pin
        assign cc_pin_oe[i] = (cm == dcc_pkg::cmp1) ||
                              (cm == dcc_pkg::cmp3) ||
                              (cm == dcc_pkg::cmp_dbl && (i % 16) < 8);
        dcc_cell u_cell (
            .mclk     (mclk),
            .rst_n    (rst_n),
            .mode     (cctl_q[i][3:0]),
            .tval     (tcnt_q[ti]),
            .upd      (upd_q[ti]),
            .ovf      (tovf_q[ti]),
            .pin_s    (pin_s2_q[i]),
            .pair_tgl (tgl[P]),
            .wr       (wr && addr == `DCC_A_VAL + 8'(i)),
            .wdata    (wdata),
            .val_q    (ccv[i]),
            .ev_q     (ccev[i]),
            .tgl      (tgl[i]),
            .pin_q    (cc_pin_o[i])
        );
    end

    assign pri_off = addr - `DCC_A_PRI;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NCH; c++) begin
                cctl_q[c] <= '0;
            end
            for (int t = 0; t < NT; t++) begin
                trld_q[t] <= 16'h0000;
                tctl_q[t] <= '0;
            end
            for (int s = 0; s < NSRC; s++) begin
                prio_q[s] <= 4'h0;
            end
            mk_ch_q <= '0;
            mk_t_q  <= '0;
        end else if (wr) begin
            if (in_rng(addr, `DCC_A_CTL, NCH)) begin
                cctl_q[addr[4:0]] <= wdata[`DCC_CTL_W-1:0];
            end
            if (in_rng(addr, `DCC_A_TRLD, NT)) begin
                trld_q[addr[1:0]] <= wdata;
            end
            if (in_rng(addr, `DCC_A_TCTL, NT)) begin
                tctl_q[addr[1:0]] <= wdata[`DCC_TC_W-1:0];
            end
            if (addr == `DCC_A_MKLO) begin
                mk_ch_q[15:0] <= wdata;
            end
            if (addr == `DCC_A_MKHI) begin
                mk_ch_q[31:16] <= wdata;
            end
            if (addr == `DCC_A_MKT) begin
                mk_t_q <= wdata[NT-1:0];
            end
            if (in_rng(addr, `DCC_A_PRI, NSRC)) begin
                prio_q[pri_off[5:0]] <= wdata[3:0];
            end
        end
    end

    // a read clears status, but an event in that cycle still lands
    assign clr_ch = {{16{rd && addr == `DCC_A_STHI}},
                     {16{rd && addr == `DCC_A_STLO}}};
    assign clr_t  = {NT{rd && addr == `DCC_A_STT}};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ch_q <= '0;
            st_t_q  <= '0;
        end else begin
            st_ch_q <= (st_ch_q & ~clr_ch) | ccev;
            st_t_q  <= (st_t_q & ~clr_t) | tovf_q;
        end
    end

    assign pend = {st_t_q & mk_t_q, st_ch_q & mk_ch_q};
    assign irq  = |pend;

    always_comb begin
        best = 4'h0;
        for (int s = 0; s < NSRC; s++) begin
            if (pend[s] && prio_q[s] > best) begin
                best = prio_q[s];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_prio_q <= 4'h0;
        end else begin
            irq_prio_q <= best;
        end
    end

    always_comb begin
        rdata_d = 16'h0000;
        if (in_rng(addr, `DCC_A_VAL, NCH)) begin
            rdata_d = ccv[addr[4:0]];
        end else if (in_rng(addr, `DCC_A_CTL, NCH)) begin
            rdata_d = 16'(cctl_q[addr[4:0]]);
        end else if (in_rng(addr, `DCC_A_TCNT, NT)) begin
            rdata_d = tcnt_q[addr[1:0]];
        end else if (in_rng(addr, `DCC_A_TRLD, NT)) begin
            rdata_d = trld_q[addr[1:0]];
        end else if (in_rng(addr, `DCC_A_TCTL, NT)) begin
            rdata_d = 16'(tctl_q[addr[1:0]]);
        end else if (addr == `DCC_A_STLO) begin
            rdata_d = st_ch_q[15:0];
        end else if (addr == `DCC_A_STHI) begin
            rdata_d = st_ch_q[31:16];
        end else if (addr == `DCC_A_STT) begin
            rdata_d = 16'(st_t_q);
        end else if (addr == `DCC_A_MKLO) begin
            rdata_d = mk_ch_q[15:0];
        end else if (addr == `DCC_A_MKHI) begin
            rdata_d = mk_ch_q[31:16];
        end else if (addr == `DCC_A_MKT) begin
            rdata_d = 16'(mk_t_q);
        end else if (in_rng(addr, `DCC_A_PRI, NSRC)) begin
            rdata_d = 16'(prio_q[pri_off[5:0]]);
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rd ? rdata_d : 16'h0000;
        end
    end

    psc_res_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (cnt_en[0] && tctl_q[0][`DCC_TC_SRC +: 2] == 2'h0)
        |-> ((int'(psc_q) % RES_CYC) == RES_CYC - 1))
        else $error("prescaled step finer than resolution");
    cnt_inc_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (cnt_en[0] && !twr[0] && tcnt_q[0] != `DCC_TMAX)
        |=> (tcnt_q[0] == $past(tcnt_q[0]) + 16'h0001 && upd_q[0]))
        else $error("timer did not step by one");
    reload_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (cnt_en[2] && !twr[2] && tcnt_q[2] == `DCC_TMAX)
        |=> (tcnt_q[2] == $past(trld_q[2]) && tovf_q[2]) ##1 st_t_q[2])
        else $error("overflow reload or flag missing");
    gm2_src_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tctl_q[2][`DCC_TC_RUN] && tctl_q[2][`DCC_TC_SRC +: 2] == 2'h1
         && gm2_t6_ovf) |-> cnt_en[2])
        else $error("module-two overflow not counted");
    ext_src_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tctl_q[2][`DCC_TC_RUN] && tctl_q[2][`DCC_TC_SRC +: 2] == 2'h2
         && ext_edge[1]) |-> cnt_en[2])
        else $error("external count edge not counted");
    ext_none_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tctl_q[1][`DCC_TC_SRC +: 2] == 2'h2) |-> !cnt_en[1])
        else $error("second timer counted external input");
    sticky_irq_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (ccev[0] && mk_ch_q[0]) |=> (irq && st_ch_q[0]))
        else $error("channel event lost or not signalled");
    status_clr_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (rd && addr == `DCC_A_STLO && !ccev[0]) |=> !st_ch_q[0])
        else $error("status bit survived its read");
    ovf_at_max_a: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (cnt_en[2] && !twr[2] && tcnt_q[2] != `DCC_TMAX) |=> !tovf_q[2])
        else $error("timer overflow flagged below full count");
endmodule
`default_nettype wire

// ==== dcc_pins.sv ====
// Purpose: far-side model of the channel pins and the count source
// Assumes: shares mclk with the block
// Notes:   an undriven pin shows the level the bench asks for
`timescale 1ns/10ps
`default_nettype none
module dcc_pins (
    input  wire logic        mclk,
    input  wire logic [31:0] pin_o,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext_lvl,
    input  wire logic        ovf_req,
    output logic      [31:0] pin_i,
    output logic             t6_ovf
);
    // a driven pin reads back what the channel puts on it
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
    // same-clock one-cycle overflow pulse, as the other timer gives it
    always_ff @(posedge mclk) begin
        t6_ovf <= ovf_req;
    end
endmodule
`default_nettype wire

// ==== dual_capture_compare_array_bench.sv ====
// Purpose: self-checking bench for the capture/compare arrays
// Assumes: 40 MHz mclk, strobe register port
// Notes:   read data checked through a queue of expected values
`timescale 1ns/10ps
`default_nettype none
`include "dcc_params.svh"
module dual_capture_compare_array_bench;
    logic        mclk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata_q;
    logic [31:0] pin_i;
    logic [31:0] pin_o;
    logic [31:0] pin_oe;
    logic [31:0] ext_lvl;
    logic [1:0]  ext_cnt;
    logic        ovf_req;
    logic        t6_ovf;
    logic        irq;
    logic [3:0]  prio;
    logic        rd_q;
    logic [15:0] exp_q[$];
    logic [15:0] r;
    logic [15:0] d;
    logic [7:0]  a;
    int          miscompares;
    int          check_count;
    int          seed;

    dcc_top uut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .cc_pin_i(pin_i), .cc_pin_o(pin_o), .cc_pin_oe(pin_oe),
        .ext_cnt_a(ext_cnt[0]), .ext_cnt_b(ext_cnt[1]), .gm2_t6_ovf(t6_ovf),
        .irq(irq), .irq_prio_q(prio));
    dcc_pins far (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .ext_lvl(ext_lvl), .ovf_req(ovf_req), .pin_i(pin_i),
        .t6_ovf(t6_ovf));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic rr,
                       input logic [7:0] ad, input logic [15:0] dd);
        @(posedge mclk);
        wr <= w;
        rd <= rr;
        addr <= ad;
        wdata <= dd;
    endtask

    task automatic wreg(input logic [7:0] ad, input logic [15:0] dd);
        bus(1'b1, 1'b0, ad, dd);
    endtask

    // expected value is queued before the strobe goes out
    task automatic rreg(input logic [7:0] ad, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, ad, 16'h0000);
    endtask

    task automatic idle(input int n);
        bus(1'b0, 1'b0, 8'h00, 16'h0000);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wait_pin(input int n, input logic v);
        int k;
        k = 0;
        while (pin_o[n] !== v && k < 60) begin
            @(negedge mclk);
            k++;
        end
        chk("pin", {15'h0, v}, {15'h0, pin_o[n]});
    endtask

    // one overflow pulse, then time for step, match and status
    task automatic pulse;
        @(posedge mclk);
        ovf_req <= 1'b1;
        @(posedge mclk);
        ovf_req <= 1'b0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge mclk) rd_q <= rd;
    always @(negedge mclk) begin
        if (rd_q === 1'b1 && exp_q.size() > 0) begin
            r = exp_q.pop_front();
            chk("rdata", r, rdata_q);
        end
    end

    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        report_and_stop;
    end

    initial begin
        seed = 26762;
        miscompares = 0;
        check_count = 0;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        ext_lvl = 32'h0;
        ext_cnt = 2'b00;
        ovf_req = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk("irq", 16'h0, {15'h0, irq});
        chk("oe", 16'h0, pin_oe[15:0]);
        wreg(8'hff, 16'h1234);
        rreg(8'hff, 16'h0000);
        rreg(8'h20, 16'h0000);
        rreg(`DCC_A_STLO, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            a = 8'($random(seed)) & 8'h1f;
            d = 16'($random(seed));
            wreg(a, d);
            rreg(a, d);
        end
        wreg(8'h60, 16'h0009);
        wreg(8'h62, 16'h0003);
        rreg(8'h60, 16'h0009);
        // ch0 toggles, ch2 interrupt only, ch3 off on same value
        wreg(8'h20, 16'h0005);
        wreg(8'h00, 16'h0005);
        wreg(8'h22, 16'h0004);
        wreg(8'h02, 16'h0006);
        wreg(8'h23, 16'h0000);
        wreg(8'h03, 16'h0005);
        wreg(`DCC_A_MKLO, 16'h0005);
        wreg(`DCC_A_TCNT, 16'h0004);
        wreg(`DCC_A_TCTL, 16'h0001);
        idle(1);
        wait_pin(0, 1'b1);
        chk("oe0", 16'h1, {15'h0, pin_oe[0]});
        idle(20);
        chk("pin0", 16'h1, {15'h0, pin_o[0]});
        chk("oe2", 16'h0, {15'h0, pin_oe[2]});
        chk("irq", 16'h1, {15'h0, irq});
        chk("prio", 16'h9, {12'h0, prio});
        rreg(`DCC_A_STLO, 16'h0005);
        idle(3);
        chk("irq", 16'h0, {15'h0, irq});
        rreg(`DCC_A_STLO, 16'h0000);
        // capture on rising edge only, second timer held still
        wreg(8'h21, 16'h0011);
        wreg(`DCC_A_TCNT + 8'h01, d);
        idle(2);
        ext_lvl[1] <= 1'b1;
        idle(8);
        chk("oe1", 16'h0, {15'h0, pin_oe[1]});
        rreg(8'h01, d);
        rreg(`DCC_A_STLO, 16'h0002);
        wreg(8'h01, 16'h0000);
        ext_lvl[1] <= 1'b0;
        idle(8);
        rreg(8'h01, 16'h0000);
        rreg(`DCC_A_STLO, 16'h0000);
        // mode 3 on timer 2 stepped by the overflow pulse, with reload
        wreg(8'h30, 16'h0007);
        wreg(8'h10, 16'hfffe);
        wreg(`DCC_A_TRLD + 8'h02, 16'hfff0);
        wreg(`DCC_A_TCNT + 8'h02, 16'hfffd);
        wreg(`DCC_A_MKT, 16'h0004);
        wreg(`DCC_A_TCTL + 8'h02, 16'h0003);
        idle(1);
        pulse;
        chk("pin16", 16'h1, {15'h0, pin_o[16]});
        chk("oe16", 16'h1, {15'h0, pin_oe[16]});
        pulse;
        chk("irq", 16'h0, {15'h0, irq});
        pulse;
        chk("pin16", 16'h0, {15'h0, pin_o[16]});
        chk("irq", 16'h1, {15'h0, irq});
        rreg(`DCC_A_TCNT + 8'h02, 16'hfff0);
        rreg(`DCC_A_STT, 16'h0004);
        rreg(`DCC_A_STHI, 16'h0001);
        // mode 2 and mode 0 share a value; the timer is set back once
        wreg(8'h31, 16'h0006);
        wreg(8'h11, 16'hfff1);
        wreg(8'h32, 16'h0004);
        wreg(8'h12, 16'hfff1);
        wreg(8'h33, 16'h0008);
        wreg(8'h13, 16'hfff2);
        wreg(8'h3b, 16'h0008);
        wreg(8'h1b, 16'hfff3);
        idle(1);
        pulse;
        rreg(`DCC_A_STHI, 16'h0006);
        wreg(`DCC_A_TCNT + 8'h02, 16'hfff0);
        idle(1);
        pulse;
        rreg(`DCC_A_STHI, 16'h0004);
        idle(1);
        pulse;
        chk("pin19", 16'h1, {15'h0, pin_o[19]});
        chk("oe19", 16'h1, {15'h0, pin_oe[19]});
        chk("oe27", 16'h0, {15'h0, pin_oe[27]});
        pulse;
        chk("pin19", 16'h0, {15'h0, pin_o[19]});
        rreg(`DCC_A_STHI, 16'h0808);
        // both edges and falling edge only, on the stopped second timer
        wreg(8'h25, 16'h0013);
        wreg(8'h26, 16'h0012);
        wreg(8'h05, 16'h0000);
        wreg(8'h06, 16'h0000);
        idle(2);
        ext_lvl[6:5] <= 2'b11;
        idle(8);
        rreg(8'h05, d);
        rreg(8'h06, 16'h0000);
        rreg(`DCC_A_STLO, 16'h0020);
        idle(1);
        ext_lvl[6:5] <= 2'b00;
        idle(8);
        rreg(8'h06, d);
        rreg(`DCC_A_STLO, 16'h0060);
        // first timer of pair B counts edges; a second timer never does
        wreg(`DCC_A_TCTL + 8'h01, 16'h0005);
        wreg(`DCC_A_TCTL + 8'h02, 16'h0005);
        wreg(`DCC_A_TCNT + 8'h02, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            idle(2);
            ext_cnt <= 2'b11;
            idle(2);
            ext_cnt <= 2'b00;
        end
        idle(4);
        rreg(`DCC_A_TCNT + 8'h01, d);
        rreg(`DCC_A_TCNT + 8'h02, 16'h0003);
        idle(3);
        report_and_stop;
    end
endmodule
`default_nettype wire
